// ==== pkg/axis_home_and_sync_trigger_params.svh ====
// Register offsets, field positions, reset values and command codes.
`ifndef AXIS_HOME_AND_SYNC_TRIGGER_PARAMS_SVH
`define AXIS_HOME_AND_SYNC_TRIGGER_PARAMS_SVH
`define OFS_HOME_MODE 6'h00
`define OFS_COMMAND 6'h04
`define OFS_OFFSET_COUNT 6'h08
`define OFS_DRIVE_SPEED 6'h0C
`define OFS_HOME_SPEED 6'h10
`define OFS_SYNC_TRIGGER_SELECT 6'h14
`define OFS_AXIS_CONFIG 6'h18
`define OFS_AXIS_ERROR_STATUS 6'h1C
`define OFS_LOGICAL_POSITION 6'h20
`define MODE_DIR_BIT 0
`define MODE_AND_HOME_BIT 1
`define MODE_CLEAR_POS_BIT 2
`define MODE_SKIP_NEAR_BIT 3
`define CFG_COMPARE_SOURCE_BIT 5
`define ERR_LIMIT_PLUS_BIT 2
`define ERR_LIMIT_MINUS_BIT 3
`define ERR_INDEX_BIT 7
`define STATUS_BUSY_BIT 8
`define CMD_POSITION_READ 8'h10
`define CMD_SYNC_ACTIVATE 8'h64
`define CMD_HOME_START 8'h62
`define CMD_OWN_AXIS_BIT 8
`define SEL_OTHER_LSB 13
`define RST_HOME_MODE 4'h0
`define RST_SPEED 16'h0063
`define RST_OFFSET_COUNT 32'h0000_0000
`endif

// ==== pkg/axis_home_and_sync_trigger_pkg.sv ====
// Types shared by the home search and synchronous trigger block.
package axis_home_and_sync_trigger_pkg;
    typedef enum logic [2:0] {
        HS_IDLE,
        HS_NEAR,
        HS_HOME,
        HS_INDEX,
        HS_OFFSET
    } home_state_e;
endpackage

// ==== rtl/axis_home_and_sync_trigger.sv ====
// Per-axis home search sequencer and synchronous action trigger logic.
// Notes on behaviour
// - Home search runs four stages alone: fast, slow home, slow index, offset.
// - Index stage pulses at home speed, no ramp, halts at index.
// - Optionally index stage stops only when index and home are both active.
// - Index already active at index stage start sets error D7, ends search.
// - Search limit active before index stage sets D2/D3, ends search.
// - Search limit during index stage aborts, sets D2/D3, ends search.
// - Offset stage emits exactly the programmed pulse count at drive speed.
// - Optionally both position counters clear after the offset move.
// - Limit before or during offset stage stops with D2/D3 error.
// - Ten trigger events, each enabled by its bit, D4 start, D5 end.
// - D0 fires at counter at or above upper compare, source from config D5.
// - D1 fires when counter drops below upper compare.
// - D2 fires below lower compare, D3 at or above lower compare.
// - D6 and D7 fire on rising and falling trigger input edges.
// - D8 fires on the position read command 10h.
// - D9 fires on an activation command addressed to this axis.
// - D13 to D15 pass the trigger on to the other three axes.
`timescale 1ns/1ps
`include "axis_home_and_sync_trigger_params.svh"
module axis_home_and_sync_trigger #(
    parameter int SPEED_W = 16
) (
    // Clock, reset and clock enable
    input wire logic i_clk,
    input wire logic i_arst_n,
    input wire logic i_ce,
    // Avalon-MM slave
    input wire logic [5:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Sensor pins
    input wire logic i_limit_plus,
    input wire logic i_limit_minus,
    input wire logic i_near_home,
    input wire logic i_home_sensor_input,
    input wire logic i_encoder_index_input,
    input wire logic i_sync_trigger_input,
    // Position and compare values
    input wire logic signed [31:0] i_real_pos,
    input wire logic signed [31:0] i_comp_upper,
    input wire logic signed [31:0] i_comp_lower,
    output logic o_real_pos_clear,
    // Drive pulses
    output logic o_pulse_plus,
    output logic o_pulse_minus,
    // Synchronous action
    input wire logic [2:0] i_cross_activate,
    output logic o_sync_action,
    output logic [2:0] o_other_axis_activate
);
    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [5:0] pin_raw;
    logic [5:0] sync1_reg;
    logic [5:0] sync2_reg;
    assign pin_raw = {i_sync_trigger_input, i_encoder_index_input, i_home_sensor_input,
                      i_near_home, i_limit_minus, i_limit_plus};
    genvar g;
    generate
        for (g = 0; g < 6; g++) begin : g_sync
            always_ff @(posedge i_clk or negedge i_arst_n) begin
                if (!i_arst_n) begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                end else if (i_ce) begin
                    sync1_reg[g] <= pin_raw[g];
                    sync2_reg[g] <= sync1_reg[g];
                end
            end
        end
    endgenerate
    logic lim_p, lim_m, near_s, home_s, idx_s, trig_s;
    assign {trig_s, idx_s, home_s, near_s, lim_m, lim_p} = sync2_reg;

    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    logic ack_reg;
    logic wr_en;
    logic [3:0] mode_reg;
    logic [31:0] offset_count_reg;
    logic [SPEED_W-1:0] drive_speed_reg;
    logic [SPEED_W-1:0] home_speed_reg;
    logic [15:0] sync_trigger_select_reg;
    logic [15:0] axis_config_reg;
    logic [7:0] err_reg;
    logic signed [31:0] lpos_reg;
    axis_home_and_sync_trigger_pkg::home_state_e state_reg;
    logic busy;
    logic cmd_wr;
    logic home_start, position_read_trigger_cmd, own_cmd;
    // One wait cycle lets read data come straight from a flip-flop.
    assign o_waitrequest = (i_read | i_write) & ~ack_reg;
    assign wr_en = i_write & ack_reg;
    assign busy = state_reg != axis_home_and_sync_trigger_pkg::HS_IDLE;
    assign cmd_wr = wr_en && i_address == `OFS_COMMAND;
    assign home_start = cmd_wr && i_writedata[7:0] == `CMD_HOME_START;
    assign position_read_trigger_cmd = cmd_wr && i_writedata[7:0] == `CMD_POSITION_READ;
    assign own_cmd = cmd_wr && i_writedata[7:0] == `CMD_SYNC_ACTIVATE
                     && i_writedata[`CMD_OWN_AXIS_BIT];
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_reg <= 1'b0;
            o_readdata <= 32'h0000_0000;
        end else if (i_ce) begin
            ack_reg <= (i_read | i_write) & ~ack_reg;
            if (i_read & ~ack_reg) begin
                if (i_address == `OFS_HOME_MODE) begin
                    o_readdata <= {28'h000_0000, mode_reg};
                end else if (i_address == `OFS_OFFSET_COUNT) begin
                    o_readdata <= offset_count_reg;
                end else if (i_address == `OFS_DRIVE_SPEED) begin
                    o_readdata <= 32'(drive_speed_reg);
                end else if (i_address == `OFS_HOME_SPEED) begin
                    o_readdata <= 32'(home_speed_reg);
                end else if (i_address == `OFS_AXIS_CONFIG) begin
                    o_readdata <= {16'h0000, axis_config_reg};
                end else if (i_address == `OFS_AXIS_ERROR_STATUS) begin
                    o_readdata <= {23'h00_0000, busy, err_reg};
                end else if (i_address == `OFS_LOGICAL_POSITION) begin
                    o_readdata <= lpos_reg;
                end else begin
                    o_readdata <= 32'h0000_0000;
                end
            end
        end
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            mode_reg <= `RST_HOME_MODE;
            offset_count_reg <= `RST_OFFSET_COUNT;
            drive_speed_reg <= SPEED_W'(`RST_SPEED);
            home_speed_reg <= SPEED_W'(`RST_SPEED);
            sync_trigger_select_reg <= 16'h0000;
            axis_config_reg <= 16'h0000;
        end else if (i_ce && wr_en) begin
            if (i_address == `OFS_HOME_MODE) begin
                mode_reg <= i_writedata[3:0];
            end else if (i_address == `OFS_OFFSET_COUNT) begin
                offset_count_reg <= i_writedata;
            end else if (i_address == `OFS_DRIVE_SPEED) begin
                drive_speed_reg <= i_writedata[SPEED_W-1:0];
            end else if (i_address == `OFS_HOME_SPEED) begin
                home_speed_reg <= i_writedata[SPEED_W-1:0];
            end else if (i_address == `OFS_SYNC_TRIGGER_SELECT) begin
                sync_trigger_select_reg <= i_writedata[15:0];
            end else if (i_address == `OFS_AXIS_CONFIG) begin
                axis_config_reg <= i_writedata[15:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Home search sequencer
    // ----------------------------------------------------------------
    logic dir, lim_dir, step, index_hit;
    logic [31:0] remain_reg;
    logic [SPEED_W-1:0] rate_reg, period;
    logic [2:0] lim_err_bit;
    logic finish_clear;
    assign dir = mode_reg[`MODE_DIR_BIT];
    assign lim_dir = dir ? lim_m : lim_p;
    assign lim_err_bit = dir ? 3'(`ERR_LIMIT_MINUS_BIT) : 3'(`ERR_LIMIT_PLUS_BIT);
    assign index_hit = idx_s && (!mode_reg[`MODE_AND_HOME_BIT] || home_s);
    assign finish_clear = state_reg == axis_home_and_sync_trigger_pkg::HS_OFFSET
                          && !lim_dir && remain_reg == 32'h0000_0000
                          && mode_reg[`MODE_CLEAR_POS_BIT];
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            state_reg <= axis_home_and_sync_trigger_pkg::HS_IDLE;
            err_reg <= 8'h00;
            remain_reg <= 32'h0000_0000;
        end else if (i_ce) begin
            case (state_reg)
                axis_home_and_sync_trigger_pkg::HS_IDLE: begin
                    if (home_start) begin
                        err_reg <= 8'h00;
                        state_reg <= mode_reg[`MODE_SKIP_NEAR_BIT]
                            ? axis_home_and_sync_trigger_pkg::HS_HOME
                            : axis_home_and_sync_trigger_pkg::HS_NEAR;
                    end
                end
                axis_home_and_sync_trigger_pkg::HS_NEAR: begin
                    if (near_s || lim_dir) begin
                        state_reg <= axis_home_and_sync_trigger_pkg::HS_HOME;
                    end
                end
                axis_home_and_sync_trigger_pkg::HS_HOME: begin
                    if (home_s || lim_dir) begin
                        if (home_s && idx_s) begin
                            err_reg[`ERR_INDEX_BIT] <= 1'b1;
                            state_reg <= axis_home_and_sync_trigger_pkg::HS_IDLE;
                        end else if (lim_dir) begin
                            err_reg[lim_err_bit] <= 1'b1;
                            state_reg <= axis_home_and_sync_trigger_pkg::HS_IDLE;
                        end else begin
                            state_reg <= axis_home_and_sync_trigger_pkg::HS_INDEX;
                        end
                    end
                end
                axis_home_and_sync_trigger_pkg::HS_INDEX: begin
                    if (lim_dir) begin
                        err_reg[lim_err_bit] <= 1'b1;
                        state_reg <= axis_home_and_sync_trigger_pkg::HS_IDLE;
                    end else if (index_hit) begin
                        remain_reg <= offset_count_reg;
                        state_reg <= axis_home_and_sync_trigger_pkg::HS_OFFSET;
                    end
                end
                axis_home_and_sync_trigger_pkg::HS_OFFSET: begin
                    if (lim_dir) begin
                        err_reg[lim_err_bit] <= 1'b1;
                        state_reg <= axis_home_and_sync_trigger_pkg::HS_IDLE;
                    end else if (remain_reg == 32'h0000_0000) begin
                        state_reg <= axis_home_and_sync_trigger_pkg::HS_IDLE;
                    end else if (step) begin
                        remain_reg <= remain_reg - 32'h0000_0001;
                    end
                end
                default: begin
                    state_reg <= axis_home_and_sync_trigger_pkg::HS_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pulse generator
    // ----------------------------------------------------------------
    // Constant rate with no ramp: the slow stages stop within one pulse.
    assign period = (state_reg == axis_home_and_sync_trigger_pkg::HS_NEAR
                     || state_reg == axis_home_and_sync_trigger_pkg::HS_OFFSET)
                    ? drive_speed_reg : home_speed_reg;
    assign step = busy && !lim_dir && rate_reg >= period
                  && !(state_reg == axis_home_and_sync_trigger_pkg::HS_INDEX && index_hit)
                  && !(state_reg == axis_home_and_sync_trigger_pkg::HS_OFFSET
                       && remain_reg == 32'h0000_0000);
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rate_reg <= '0;
            o_pulse_plus <= 1'b0;
            o_pulse_minus <= 1'b0;
        end else if (i_ce) begin
            rate_reg <= (step || !busy) ? '0 : rate_reg + 1'b1;
            o_pulse_plus <= step && !dir;
            o_pulse_minus <= step && dir;
        end
    end
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lpos_reg <= 32'sh0000_0000;
            o_real_pos_clear <= 1'b0;
        end else if (i_ce) begin
            o_real_pos_clear <= finish_clear;
            if (finish_clear) begin
                lpos_reg <= 32'sh0000_0000;
            end else if (step) begin
                lpos_reg <= dir ? lpos_reg - 32'sh0000_0001 : lpos_reg + 32'sh0000_0001;
            end
        end
    end

    // ----------------------------------------------------------------
    // Synchronous action trigger
    // ----------------------------------------------------------------
    logic signed [31:0] pos;
    logic [3:0] cond, cond_reg;
    logic busy_reg, trig_reg;
    logic [9:0] events;
    logic fire;
    assign pos = axis_config_reg[`CFG_COMPARE_SOURCE_BIT] ? i_real_pos : lpos_reg;
    assign cond = {pos >= i_comp_lower, pos < i_comp_lower,
                   pos < i_comp_upper, pos >= i_comp_upper};
    assign events = {own_cmd, position_read_trigger_cmd, trig_reg & ~trig_s, ~trig_reg & trig_s,
                     busy_reg & ~busy, ~busy_reg & busy, cond & ~cond_reg};
    assign fire = |(events & sync_trigger_select_reg[9:0]);
    // Cross activations are not passed on again, so axes cannot loop.
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cond_reg <= 4'h0;
            busy_reg <= 1'b0;
            trig_reg <= 1'b0;
            o_sync_action <= 1'b0;
            o_other_axis_activate <= 3'h0;
        end else if (i_ce) begin
            cond_reg <= cond;
            busy_reg <= busy;
            trig_reg <= trig_s;
            o_sync_action <= fire | (|i_cross_activate);
            o_other_axis_activate <= {3{fire}} & sync_trigger_select_reg[15:`SEL_OTHER_LSB];
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    property p_index_pulse_dir;
        state_reg == axis_home_and_sync_trigger_pkg::HS_INDEX && i_ce && step
        |=> (o_pulse_minus == dir) && (o_pulse_plus == !dir);
    endproperty
    a_index_pulse_dir: assert property (p_index_pulse_dir) else $error("wrong pulse");
    property p_and_hold;
        state_reg == axis_home_and_sync_trigger_pkg::HS_INDEX && i_ce
        && mode_reg[`MODE_AND_HOME_BIT] && !home_s && !lim_dir
        |=> state_reg == axis_home_and_sync_trigger_pkg::HS_INDEX;
    endproperty
    a_and_hold: assert property (p_and_hold) else $error("index left early");
    property p_index_err;
        state_reg == axis_home_and_sync_trigger_pkg::HS_HOME && i_ce && home_s && idx_s
        |=> err_reg[`ERR_INDEX_BIT] && !busy;
    endproperty
    a_index_err: assert property (p_index_err) else $error("no index error");
    property p_limit_abort;
        (state_reg == axis_home_and_sync_trigger_pkg::HS_INDEX
         || state_reg == axis_home_and_sync_trigger_pkg::HS_OFFSET) && i_ce && lim_dir
        |=> !busy && err_reg[lim_err_bit] && !o_pulse_plus && !o_pulse_minus;
    endproperty
    a_limit_abort: assert property (p_limit_abort) else $error("no limit stop");
    property p_offset_done;
        state_reg == axis_home_and_sync_trigger_pkg::HS_OFFSET && i_ce && !lim_dir
        && remain_reg == 32'h0000_0000 |=> !busy && err_reg == 8'h00;
    endproperty
    a_offset_done: assert property (p_offset_done) else $error("offset not done");
    property p_clear_pos;
        i_ce && finish_clear |=> lpos_reg == 32'sh0000_0000 && o_real_pos_clear;
    endproperty
    a_clear_pos: assert property (p_clear_pos) else $error("position not cleared");
    property p_start_fire;
        i_ce && home_start && !busy && sync_trigger_select_reg[4]
        ##1 i_ce |=> o_sync_action;
    endproperty
    a_start_fire: assert property (p_start_fire) else $error("start missed");
    property p_rise_fire;
        i_ce && !trig_reg && trig_s && sync_trigger_select_reg[6] |=> o_sync_action;
    endproperty
    a_rise_fire: assert property (p_rise_fire) else $error("edge missed");
    property p_other;
        o_other_axis_activate != 3'h0 |-> o_sync_action;
    endproperty
    a_other: assert property (p_other) else $error("cross without action");
endmodule

// ==== testbench/axis_drive_sensor_model.sv ====
// Behavioural model of the motor drive, encoder index and axis sensors.
`timescale 1ns/1ps
module axis_drive_sensor_model (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_arst_n,
    // Drive pulses and counter clear
    input wire logic i_pulse_plus,
    input wire logic i_pulse_minus,
    input wire logic i_pos_clear,
    // Bench controls
    input wire logic i_index_en,
    input wire logic i_force_index,
    input wire logic i_force_limit,
    // Counter and sensor levels
    output logic signed [31:0] o_pos,
    output logic o_near,
    output logic o_home,
    output logic o_index,
    output logic o_limit_plus,
    output logic o_limit_minus
);
    // ----
    // Real position counter
    // ----
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pos <= 32'sh0;
        end else if (i_pos_clear) begin
            o_pos <= 32'sh0;
        end else begin
            o_pos <= o_pos + 32'(i_pulse_plus) - 32'(i_pulse_minus);
        end
    end
    // The home sensor is narrow so that the index at 13 falls outside it and
    // the index at 21 inside the second home band.
    assign o_near = (o_pos >= 5);
    assign o_home = (o_pos >= 10 && o_pos < 13) || (o_pos >= 20 && o_pos < 24);
    assign o_index = i_force_index || (i_index_en && o_pos > 0 && o_pos[2:0] == 3'h5);
    assign o_limit_plus = i_force_limit;
    assign o_limit_minus = (o_pos < -64);
endmodule

// ==== testbench/axis_home_and_sync_trigger_tb.sv ====
// Self-checking bench for the home search and synchronous trigger block.
`timescale 1ns/1ps
`include "axis_home_and_sync_trigger_params.svh"
module axis_home_and_sync_trigger_tb;
    logic i_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic [5:0] i_address = 6'h00;
    logic i_read = 1'b0;
    logic i_write = 1'b0;
    logic [31:0] i_writedata = 32'h0;
    logic [31:0] o_readdata;
    logic o_waitrequest;
    logic lim_p, lim_m, near, home, index, pclr, pp, pm, act;
    logic trig = 1'b0;
    logic signed [31:0] pos;
    logic signed [31:0] up = 32'sh0;
    logic signed [31:0] lo = 32'sh0;
    logic [2:0] oth;
    logic [2:0] oth_last = 3'h0;
    logic idx_en = 1'b1;
    logic f_idx = 1'b0;
    logic f_lim = 1'b0;
    logic signed [31:0] lim_at = 32'sh0;
    logic signed [31:0] clr_pos = 32'sh0;
    int act_cnt = 0;
    int miscompares = 0;
    int tests_run = 0;
    int evs[8] = '{0, 1, 2, 3, 6, 7, 8, 9};

    always #4 i_clk = ~i_clk;

    axis_home_and_sync_trigger DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(1'b1),
        .i_address(i_address), .i_read(i_read), .i_write(i_write),
        .i_writedata(i_writedata), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest),
        .i_limit_plus(lim_p), .i_limit_minus(lim_m), .i_near_home(near),
        .i_home_sensor_input(home), .i_encoder_index_input(index),
        .i_sync_trigger_input(trig), .i_real_pos(pos), .i_comp_upper(up),
        .i_comp_lower(lo), .o_real_pos_clear(pclr), .o_pulse_plus(pp),
        .o_pulse_minus(pm), .i_cross_activate(3'h0), .o_sync_action(act),
        .o_other_axis_activate(oth));

    axis_drive_sensor_model model (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_pulse_plus(pp),
        .i_pulse_minus(pm), .i_pos_clear(pclr), .i_index_en(idx_en),
        .i_force_index(f_idx), .i_force_limit(f_lim), .o_pos(pos), .o_near(near),
        .o_home(home), .o_index(index), .o_limit_plus(lim_p), .o_limit_minus(lim_m));

    // ----
    // Event recorders
    // ----
    always @(posedge i_clk) begin
        if (!i_arst_n) begin
            act_cnt <= 0;
            f_lim <= 1'b0;
        end else begin
            if (act === 1'b1) begin
                act_cnt <= act_cnt + 1;
                oth_last <= oth;
            end
            if (lim_at != 0 && pos >= lim_at) f_lim <= 1'b1;
        end
        if (pclr === 1'b1) clr_pos <= pos;
    end

    task automatic end_sim();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic timeout(input string what);
        miscompares++;
        $display("[ERR] %0t wait for %s ran out", $time, what);
        end_sim();
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // The request is held until an edge samples waitrequest low; read data is
    // taken at that same edge, before the slave's own updates land.
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        logic w;
        int n;
        n = 0;
        @(posedge i_clk);
        i_read <= ~wr;
        i_write <= wr;
        i_address <= a;
        i_writedata <= d;
        do begin
            @(posedge i_clk);
            w = o_waitrequest;
            q = o_readdata;
            n++;
        end while (w !== 1'b0 && n < 50);
        i_read <= 1'b0;
        i_write <= 1'b0;
        if (w !== 1'b0) timeout("bus");
    endtask

    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rd_check(input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q, exp, "read");
    endtask

    task automatic do_reset();
        i_arst_n <= 1'b0;
        lim_at <= 32'sh0;
        repeat (5) @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        wr(`OFS_DRIVE_SPEED, 32'h2);
        wr(`OFS_HOME_SPEED, 32'h7);
    endtask

    task automatic home_run(input logic [31:0] mode, input logic [31:0] cnt,
                            input logic [31:0] exp);
        logic [31:0] q;
        int n;
        n = 0;
        wr(`OFS_HOME_MODE, mode);
        wr(`OFS_OFFSET_COUNT, cnt);
        wr(`OFS_COMMAND, {24'h0, `CMD_HOME_START});
        do begin
            bus(1'b0, `OFS_AXIS_ERROR_STATUS, 32'h0, q);
            n++;
        end while (q[`STATUS_BUSY_BIT] !== 1'b0 && n < 500);
        if (n >= 500) timeout("home search");
        check(q, exp, "status");
    endtask

    // Puts the selected condition in its false state, arms it, then makes it true.
    task automatic fire(input int b);
        logic [31:0] sel;
        logic signed [31:0] far;
        int old;
        int n;
        far = 32'($urandom_range(1, 1000));
        sel = (32'h1 << b) | {16'h0, 3'($urandom), 13'h0};
        up <= (b == 1) ? -far : far;
        lo <= (b == 2) ? -far : far;
        trig <= (b == 7);
        repeat (6) @(posedge i_clk);
        wr(`OFS_SYNC_TRIGGER_SELECT, sel);
        old = act_cnt;
        if (b < 2) up <= (b == 0) ? -far : far;
        else if (b < 4) lo <= (b == 3) ? -far : far;
        else if (b < 8) trig <= (b == 6);
        else wr(`OFS_COMMAND, (b == 8) ? 32'h10 : 32'h164);
        n = 0;
        while (act_cnt == old && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        check(act_cnt - old, 32'h1, "action count");
        check({29'h0, oth_last}, {29'h0, sel[15:13]}, "other axes");
    endtask

    initial begin
        logic [31:0] base;
        logic [31:0] cnt;
        void'($urandom(32'h00d3f5e2));
        do_reset();
        rd_check(`OFS_OFFSET_COUNT, 32'h0);
        rd_check(`OFS_HOME_MODE, 32'h0);
        rd_check(`OFS_AXIS_ERROR_STATUS, 32'h0);
        wr(`OFS_SYNC_TRIGGER_SELECT, 32'h0200);
        rd_check(`OFS_SYNC_TRIGGER_SELECT, 32'h0);
        wr(`OFS_SYNC_TRIGGER_SELECT, 32'h0);
        wr(6'h3C, 32'hFFFF_FFFF);
        rd_check(6'h3C, 32'h0);
        i_arst_n <= 1'b0;
        @(posedge i_clk);
        i_arst_n <= 1'b1;
        repeat (3) @(posedge i_clk);
        rd_check(`OFS_HOME_SPEED, 32'h63);
        rd_check(`OFS_DRIVE_SPEED, 32'h63);
        wr(`OFS_DRIVE_SPEED, 32'h2);
        wr(`OFS_HOME_SPEED, 32'h7);
        // Clean runs; the pair of counts gives the offset length exactly.
        wr(`OFS_SYNC_TRIGGER_SELECT, 32'h10);
        home_run(32'h4, 32'h0, 32'h0);
        base = clr_pos;
        check(act_cnt, 32'h1, "drive start");
        check(pos, 32'h0, "real cleared");
        rd_check(`OFS_LOGICAL_POSITION, 32'h0);
        do_reset();
        cnt = $urandom_range(1, 15);
        wr(`OFS_SYNC_TRIGGER_SELECT, 32'h20);
        home_run(32'h4, cnt, 32'h0);
        check(clr_pos, base + cnt, "offset pulses");
        check(act_cnt, 32'h1, "drive end");
        do_reset();
        home_run(32'h6, 32'h0, 32'h0);
        check(clr_pos, base + 32'h8, "index with home");
        do_reset();
        f_idx <= 1'b1;
        home_run(32'h4, 32'h0, 32'h80);
        check(act_cnt, 32'h0, "no action");
        f_idx <= 1'b0;
        do_reset();
        lim_at <= 32'sd8;
        home_run(32'h4, 32'h0, 32'h4);
        do_reset();
        idx_en <= 1'b0;
        lim_at <= 32'sd14;
        home_run(32'h4, 32'h0, 32'h4);
        idx_en <= 1'b1;
        do_reset();
        lim_at <= 32'sd16;
        home_run(32'h4, 32'd20, 32'h4);
        do_reset();
        wr(`OFS_AXIS_CONFIG, 32'h20);
        foreach (evs[i]) fire(evs[i]);
        wr(`OFS_SYNC_TRIGGER_SELECT, 32'h0);
        base = act_cnt;
        trig <= ~trig;
        repeat (12) @(posedge i_clk);
        check(act_cnt, base, "disabled event");
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge i_clk);
        timeout("run");
    end
endmodule
